// File: hw/dxm_pkg.sv
package dxm_pkg;
  // Map geometry
  localparam int          PLATES     = 4;
  localparam int          ADR_W      = 8;
  localparam int          CMD_W      = 12;
  localparam int          PTR_W      = 16;
  localparam int          IRQ_W      = 2;
  localparam int          STAT_IN_W  = 8;

  // Output image words, byte address = image byte
  localparam logic [2:0]  W_AUX      = 3'h4;
  localparam logic [2:0]  W_SWIRL    = 3'h5;
  localparam logic [2:0]  W_PTR      = 3'h6;
  localparam logic [2:0]  W_DATA     = 3'h7;
  localparam logic [2:0]  OUT_REGION = 3'h0;

  // Field positions inside a word
  localparam int          CMD_LSB    = 0;
  localparam int          CTRL_LSB   = 16;
  localparam int          STYLE_LSB  = 24;
  localparam int          HI_LSB     = 16;
  localparam int          SPARE_BYTE = 0;
  localparam int          SPARE_N    = 2;

  // Input image and service registers
  localparam logic [7:0]  ADR_ECHO    = 8'h54;
  localparam logic [7:0]  ADR_IN_DATA = 8'h58;
  localparam logic [7:0]  ADR_STATUS  = 8'h5c;
  localparam logic [7:0]  ADR_IRQ_STS = 8'h70;
  localparam logic [7:0]  ADR_IRQ_EN  = 8'h74;
  localparam logic [7:0]  ADR_IRQ_CLR = 8'h78;

  // Per-plate status byte, heartbeat position
  localparam logic [7:0]  HB_MASK    = 8'h20;
  localparam int          IRQ_RD     = 0;
  localparam int          IRQ_WR     = 1;

  // Heartbeat timing: 0.25 Hz, one level change each half period
  localparam longint      CLK_HZ      = 50_000_000;
  localparam longint      HB_RATE_CHZ = 25;
  localparam longint      HB_HALF_CYC = (CLK_HZ * 100) / (HB_RATE_CHZ * 2);

  typedef struct packed {
    logic [7:0]       style;
    logic [7:0]       ctrl;
    logic [CMD_W-1:0] cmd;
  } dxm_plate_cmd_t;

  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [31:0]      data;
  } dxm_xchg_t;

  typedef enum logic [1:0] {
    XS_IDLE = 2'b01,
    XS_WAIT = 2'b10
  } dxm_xs_t;
endpackage : dxm_pkg

// File: hw/dxm_heartbeat.sv
`timescale 1ns/1ps
module dxm_heartbeat
  import dxm_pkg::*;
#(
  parameter int unsigned HALF = 32'(HB_HALF_CYC)
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic operating,
  output logic      hb_o
);
  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_reg;
  logic          hb_reg;

  // Half-period counter; parked at zero when idle so the level restarts clean
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (!operating || cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Level flips once per half period while running
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hb_reg <= 1'b0;
    end else if (operating && cnt_reg == LAST) begin
      hb_reg <= ~hb_reg;
    end
  end

  assign hb_o = hb_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  hb_only_on_wrap_a: assert property (
    hb_reg != $past(hb_reg) |-> $past(cnt_reg) == LAST && $past(operating))
    else $error("heartbeat changed off the half-period boundary");
endmodule : dxm_heartbeat

// File: hw/dxm_exchange.sv
`timescale 1ns/1ps
module dxm_exchange
  import dxm_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [PTR_W-1:0] ptr_cmd,
  input  wire logic [31:0]      data_cmd,
  input  wire logic             rd_ack,
  input  wire logic [31:0]      rd_data,
  output dxm_xchg_t             echo_o,
  output dxm_xchg_t             req_o,
  output logic                  wr_stb_o,
  output logic                  rd_req_o,
  output logic                  done_rd_o,
  output logic                  done_wr_o
);
  dxm_xs_t          state_reg;
  logic [PTR_W-1:0] last_reg;
  dxm_xchg_t        echo_reg;
  dxm_xchg_t        req_reg;
  logic             wr_stb_reg;
  logic             rd_req_reg;
  logic             done_rd_reg;
  logic             done_wr_reg;
  logic             fresh;

  // A request is a change of pointer to a nonzero value
  assign fresh = state_reg == XS_IDLE && ptr_cmd != last_reg && ptr_cmd != '0;

  // Odd pointers transmit, even pointers fetch from the core
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= XS_IDLE;
      last_reg    <= '0;
      echo_reg    <= '0;
      req_reg     <= '0;
      wr_stb_reg  <= 1'b0;
      rd_req_reg  <= 1'b0;
      done_rd_reg <= 1'b0;
      done_wr_reg <= 1'b0;
    end else begin
      wr_stb_reg  <= 1'b0;
      done_rd_reg <= 1'b0;
      done_wr_reg <= 1'b0;
      case (state_reg)
        XS_IDLE: begin
          last_reg <= ptr_cmd;
          if (fresh && ptr_cmd[0]) begin
            req_reg     <= '{ptr: ptr_cmd, data: data_cmd};
            echo_reg    <= '{ptr: ptr_cmd, data: data_cmd};
            wr_stb_reg  <= 1'b1;
            done_wr_reg <= 1'b1;
          end else if (fresh) begin
            req_reg    <= '{ptr: ptr_cmd, data: 32'h0};
            rd_req_reg <= 1'b1;
            state_reg  <= XS_WAIT;
          end
        end
        XS_WAIT: begin
          // Pointer echo only moves once the data is in place
          if (rd_ack) begin
            echo_reg    <= '{ptr: req_reg.ptr, data: rd_data};
            rd_req_reg  <= 1'b0;
            done_rd_reg <= 1'b1;
            state_reg   <= XS_IDLE;
          end
        end
        default: begin
          state_reg  <= XS_IDLE;
          rd_req_reg <= 1'b0;
        end
      endcase
    end
  end

  assign echo_o    = echo_reg;
  assign req_o     = req_reg;
  assign wr_stb_o  = wr_stb_reg;
  assign rd_req_o  = rd_req_reg;
  assign done_rd_o = done_rd_reg;
  assign done_wr_o = done_wr_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_fetch_done;
    state_reg == XS_WAIT && rd_ack;
  endsequence

  fetch_echo_a: assert property (
    s_fetch_done |=> echo_reg.data == $past(rd_data)
                     && echo_reg.ptr == $past(req_reg.ptr) && done_rd_reg)
    else $error("fetched data or pointer not echoed");

  send_echo_a: assert property (
    fresh && ptr_cmd[0] |=> echo_reg == {$past(ptr_cmd), $past(data_cmd)} && wr_stb_reg)
    else $error("transmit request not echoed");

  no_change_hold_a: assert property (
    state_reg == XS_IDLE && !fresh |=> echo_reg == $past(echo_reg))
    else $error("echo moved without a new pointer");
endmodule : dxm_exchange

// File: hw/dxm_top.sv
// Behaviour
// - Plate command words keep a 12-bit setpoint in the low bits; plate one at bytes 0-1.
// - Control byte bits are strobe, complete, valves 1-4, reset/cancel, remote start/purge.
// - The byte after the control byte is the 8-bit style number.
// - Plate groups repeat every four bytes, at bytes 0, 4, 8 and 12.
// - Bytes 22-23 hold the 12-bit swirl setpoint.
// - Bytes 24-25 are spare and the device ignores them.
// - The serviced pointer shows at input bytes 22-23; the controller waits for it.
// - Once the echo matches, the requested item sits at input bytes 24-27.
// - After a send the device echoes pointer and accepted data.
// - Each plate heartbeat bit flips at a 0.25 Hz rate while running.
// - Status bits: ready, no alarm, no error, dispensing, vol ok, beat, purge req, remote.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module dxm_top
  import dxm_pkg::*;
#(
  parameter int unsigned HB_HALF = 32'(HB_HALF_CYC)
) (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [ADR_W-1:0]            wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             irq_o,
  input  wire logic                        operating,
  input  wire logic [PLATES-1:0][7:0]      plate_stat_in,
  output dxm_plate_cmd_t [PLATES-1:0]      plate_cmd,
  output logic      [2:0][CMD_W-1:0]       aux_cmd,
  output logic      [CMD_W-1:0]            swirl_cmd,
  output dxm_xchg_t                        core_req,
  output logic                             core_wr_stb,
  output logic                             core_rd_req,
  input  wire logic                        core_rd_ack,
  input  wire logic [31:0]                 core_rd_data
);
  logic [7:0][31:0]      out_img_reg;
  logic [31:0]           rd_reg;
  logic [31:0]           rd_next;
  logic                  ack_reg;
  logic [IRQ_W-1:0]      irq_sts_reg;
  logic [IRQ_W-1:0]      irq_sts_next;
  logic [IRQ_W-1:0]      irq_en_reg;
  logic [IRQ_W-1:0]      irq_set;
  logic [IRQ_W-1:0]      irq_clr;
  logic                  irq_reg;
  logic                  acc;
  logic                  wr_acc;
  logic                  out_hit;
  logic [2:0]            widx;
  logic                  hb;
  logic [31:0]           stat_word;
  dxm_xchg_t             echo;
  logic                  done_rd;
  logic                  done_wr;

  // One access per request; ack drops in the cycle after it was given
  assign acc     = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_acc  = acc && wb_we_i;
  assign widx    = wb_adr_i[4:2];
  assign out_hit = wb_adr_i[7:5] == OUT_REGION;

  // Registered ack; costs a cycle per access but keeps the bus paths short
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= acc;
    end
  end

  // Output image written byte by byte; spare bytes never stored
  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_img
      localparam int W  = b / 4;
      localparam int BY = b % 4;
      localparam bit SPARE = (W == int'(W_PTR)) && (BY >= SPARE_BYTE)
                             && (BY < SPARE_BYTE + SPARE_N);
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          out_img_reg[W][BY*8 +: 8] <= 8'h00;
        end else if (!SPARE && wr_acc && out_hit && widx == 3'(W) && wb_sel_i[BY]) begin
          out_img_reg[W][BY*8 +: 8] <= wb_dat_i[BY*8 +: 8];
        end
      end
    end
  endgenerate

  // Plate groups every four bytes; setpoints cut to their 12 bits
  genvar p;
  generate
    for (p = 0; p < PLATES; p++) begin : g_plate
      assign plate_cmd[p].cmd   = out_img_reg[p][CMD_LSB +: CMD_W];
      assign plate_cmd[p].ctrl  = out_img_reg[p][CTRL_LSB +: 8];
      assign plate_cmd[p].style = out_img_reg[p][STYLE_LSB +: 8];
      // Heartbeat is ours; the core supplies the other seven flags
      assign stat_word[p*8 +: 8] = (plate_stat_in[p] & ~HB_MASK)
                                   | (hb ? HB_MASK : 8'h00);
    end
  endgenerate

  // Extra command words at bytes 16-21
  assign aux_cmd[0] = out_img_reg[W_AUX][CMD_LSB +: CMD_W];
  assign aux_cmd[1] = out_img_reg[W_AUX][HI_LSB +: CMD_W];
  assign aux_cmd[2] = out_img_reg[W_SWIRL][CMD_LSB +: CMD_W];
  assign swirl_cmd  = out_img_reg[W_SWIRL][HI_LSB +: CMD_W];

  dxm_heartbeat #(
    .HALF      (HB_HALF)
  ) u_hb (
    .clock     (clock),
    .arst_n    (arst_n),
    .operating (operating),
    .hb_o      (hb)
  );

  // Exchange engine watches the pointer and data words as the controller left them
  dxm_exchange u_xchg (
    .clock     (clock),
    .arst_n    (arst_n),
    .ptr_cmd   (out_img_reg[W_PTR][HI_LSB +: PTR_W]),
    .data_cmd  (out_img_reg[W_DATA]),
    .rd_ack    (core_rd_ack),
    .rd_data   (core_rd_data),
    .echo_o    (echo),
    .req_o     (core_req),
    .wr_stb_o  (core_wr_stb),
    .rd_req_o  (core_rd_req),
    .done_rd_o (done_rd),
    .done_wr_o (done_wr)
  );

  // Read decode; unmapped words answer zero with a normal ack
  always_comb begin
    rd_next = 32'h0;
    if (out_hit) begin
      rd_next = out_img_reg[widx];
    end else begin
      case (wb_adr_i)
        ADR_ECHO:    rd_next[HI_LSB +: PTR_W] = echo.ptr;
        ADR_IN_DATA: rd_next = echo.data;
        ADR_STATUS:  rd_next = stat_word;
        ADR_IRQ_STS: rd_next[IRQ_W-1:0] = irq_sts_reg;
        ADR_IRQ_EN:  rd_next[IRQ_W-1:0] = irq_en_reg;
        default:     rd_next = 32'h0;
      endcase
    end
  end

  // Read data captured with the ack; only valid while ack is high
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_reg <= 32'h0;
    end else if (acc && !wb_we_i) begin
      rd_reg <= rd_next;
    end
  end

  // Sticky events; a set in the clearing cycle survives
  assign irq_set = {done_wr, done_rd};
  assign irq_clr = (wr_acc && wb_adr_i == ADR_IRQ_CLR && wb_sel_i[0])
                   ? wb_dat_i[IRQ_W-1:0] : '0;
  assign irq_sts_next = (irq_sts_reg & ~irq_clr) | irq_set;

  // Status is read-only to software; only the clear register lowers it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_sts_reg <= '0;
    end else begin
      irq_sts_reg <= irq_sts_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_reg <= '0;
    end else if (wr_acc && wb_adr_i == ADR_IRQ_EN && wb_sel_i[0]) begin
      irq_en_reg <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Registered level; built from the next status so it moves with the status, and the pin stays glitch free
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_sts_next & irq_en_reg);
    end
  end

  assign wb_dat_o = rd_reg;
  assign wb_ack_o = ack_reg;
  assign irq_o    = irq_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_img_wr(logic [2:0] w, int lane);
    wr_acc && out_hit && widx == w && wb_sel_i[lane];
  endsequence

  sequence s_rd(logic [7:0] a);
    acc && !wb_we_i && wb_adr_i == a;
  endsequence

  cmd_setpoint_a: assert property (
    s_img_wr(3'h0, 0) and s_img_wr(3'h0, 1)
      |=> plate_cmd[0].cmd == $past(wb_dat_i[CMD_W-1:0]))
    else $error("plate one setpoint not taken");

  ctrl_byte_a: assert property (
    s_img_wr(3'h0, 2) |=> plate_cmd[0].ctrl == $past(wb_dat_i[CTRL_LSB +: 8]))
    else $error("control byte not taken");

  style_byte_a: assert property (
    s_img_wr(3'h1, 3) |=> plate_cmd[1].style == $past(wb_dat_i[STYLE_LSB +: 8]))
    else $error("style byte not taken");

  plate_stride_a: assert property (
    s_img_wr(3'h3, 0) and s_img_wr(3'h3, 1)
      |=> plate_cmd[3].cmd == $past(wb_dat_i[CMD_W-1:0]))
    else $error("fourth plate group misplaced");

  swirl_word_a: assert property (
    s_img_wr(W_SWIRL, 2) and s_img_wr(W_SWIRL, 3)
      |=> swirl_cmd == $past(wb_dat_i[HI_LSB +: CMD_W]))
    else $error("swirl setpoint not taken");

  spare_ignored_a: assert property (
    acc && !wb_we_i && out_hit && widx == W_PTR |=> wb_ack_o && wb_dat_o[15:0] == 16'h0)
    else $error("spare bytes read back nonzero");

  echo_read_a: assert property (
    s_rd(ADR_ECHO) |=> wb_ack_o && wb_dat_o[HI_LSB +: PTR_W] == $past(echo.ptr))
    else $error("pointer echo not returned");

  status_hb_a: assert property (
    s_rd(ADR_STATUS) |=> wb_dat_o[5] == $past(hb) && wb_dat_o[4:0] == $past(plate_stat_in[0][4:0]))
    else $error("status byte wrong");

  ack_single_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  irq_level_a: assert property (
    (irq_sts_reg & irq_en_reg) != '0 && $stable(irq_sts_reg) && $stable(irq_en_reg) |-> irq_o)
    else $error("interrupt low with an enabled event pending");

  ctrl_stride_a: assert property (
    s_img_wr(3'h2, 2) |=> plate_cmd[2].ctrl == $past(wb_dat_i[CTRL_LSB +: 8]))
    else $error("third plate control byte misplaced");

  aux_word_a: assert property (
    s_img_wr(W_AUX, 0) and s_img_wr(W_AUX, 1)
      |=> aux_cmd[0] == $past(wb_dat_i[CMD_W-1:0]))
    else $error("auxiliary setpoint not taken");

  img_readback_a: assert property (
    acc && !wb_we_i && out_hit |=> wb_dat_o == $past(out_img_reg[widx]))
    else $error("output image word read back wrong");

  ptr_store_a: assert property (
    s_img_wr(W_PTR, 2) and s_img_wr(W_PTR, 3)
      |=> out_img_reg[W_PTR][HI_LSB +: PTR_W] == $past(wb_dat_i[HI_LSB +: PTR_W]))
    else $error("pointer command not stored");

  in_data_read_a: assert property (
    s_rd(ADR_IN_DATA) |=> wb_ack_o && wb_dat_o == $past(echo.data))
    else $error("input data element not returned");

  status_top_a: assert property (
    s_rd(ADR_STATUS) |=> wb_dat_o[29] == $past(hb)
                         && wb_dat_o[31:30] == $past(plate_stat_in[3][7:6]))
    else $error("fourth plate status byte wrong");

  ack_after_req_a: assert property (
    wb_ack_o |-> $past(acc))
    else $error("ack without a request");

  fetch_event_a: assert property (
    done_rd |=> irq_sts_reg[0])
    else $error("fetch event lost");

  send_event_a: assert property (
    done_wr |=> irq_sts_reg[1])
    else $error("send event lost");

  irq_clear_a: assert property (
    irq_clr[0] && !done_rd |=> !irq_sts_reg[0])
    else $error("fetch event not cleared");

  irq_enable_a: assert property (
    wr_acc && wb_adr_i == ADR_IRQ_EN && wb_sel_i[0]
      |=> irq_en_reg == $past(wb_dat_i[IRQ_W-1:0]))
    else $error("interrupt enable not stored");

  irq_quiet_a: assert property (
    (irq_sts_reg & irq_en_reg) == '0 && $stable(irq_sts_reg) && $stable(irq_en_reg) |-> !irq_o)
    else $error("interrupt high with nothing enabled pending");

  write_only_clr_a: assert property (
    s_rd(ADR_IRQ_CLR) |=> wb_dat_o == 32'h0)
    else $error("clear register read back nonzero");
endmodule : dxm_top

// File: tb/dxm_core_model.sv
`timescale 1ns/1ps
module dxm_core_model
  import dxm_pkg::*;
#(
  parameter int unsigned SLOW_WAIT = 6
) (
  input  wire logic      clock,
  input  wire logic      arst_n,
  input  wire logic      slow,
  input  wire logic      core_rd_req,
  input  wire dxm_xchg_t core_req,
  output logic           core_rd_ack,
  output logic [31:0]    core_rd_data
);
  logic [3:0] wait_reg;
  logic       served_reg;

  // Answers one fetch per request level; a held request is never answered twice
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      core_rd_ack  <= 1'b0;
      core_rd_data <= 32'h0000_0000;
      wait_reg     <= 4'h0;
      served_reg   <= 1'b0;
    end else begin
      core_rd_ack  <= 1'b0;
      core_rd_data <= ~core_rd_data; // Data outside the ack never holds a stale value
      if (!core_rd_req) begin
        wait_reg   <= 4'h0;
        served_reg <= 1'b0;
      end else if (!served_reg) begin
        if (32'(wait_reg) >= (slow ? SLOW_WAIT : 0)) begin
          core_rd_ack  <= 1'b1;
          core_rd_data <= {~core_req.ptr, core_req.ptr};
          served_reg   <= 1'b1;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule : dxm_core_model

// File: tb/dxm_top_tb_top.sv
`timescale 1ns/1ps
module dxm_top_tb_top
  import dxm_pkg::*;
;
  logic                        clock, arst_n, wb_cyc, wb_stb, wb_we, operating, slow;
  logic [7:0]                  wb_adr;
  logic [3:0]                  wb_sel;
  logic [31:0]                 wb_wdat, wb_rdat, rd, core_rd_data;
  logic                        wb_ack, irq_o, core_wr_stb, core_rd_req, core_rd_ack;
  logic [PLATES-1:0][7:0]      plate_stat_in;
  dxm_plate_cmd_t [PLATES-1:0] plate_cmd;
  logic [2:0][CMD_W-1:0]       aux_cmd;
  logic [CMD_W-1:0]            swirl_cmd;
  dxm_xchg_t                   core_req;
  int                          error_cnt, cmp_count, wr_cnt, ntog, n;

  dxm_top #(.HB_HALF(8)) dxm_top_inst (
    .clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq_o), .operating(operating),
    .plate_stat_in(plate_stat_in), .plate_cmd(plate_cmd), .aux_cmd(aux_cmd),
    .swirl_cmd(swirl_cmd), .core_req(core_req), .core_wr_stb(core_wr_stb),
    .core_rd_req(core_rd_req), .core_rd_ack(core_rd_ack), .core_rd_data(core_rd_data)
  );

  dxm_core_model dxm_core_model_inst (
    .clock(clock), .arst_n(arst_n), .slow(slow), .core_rd_req(core_rd_req),
    .core_req(core_req), .core_rd_ack(core_rd_ack), .core_rd_data(core_rd_data)
  );

  // Clock, 20 ns period
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Send strobes seen, so spare writes and repeated pointers can be shown to do nothing
  always @(posedge clock) begin
    if (core_wr_stb === 1'b1) wr_cnt++;
  end

  task report_and_stop;
    $display("Mismatches %0d, compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD %0t: got %h expected %h", $time, seen, want);
    end
  endtask : check

  // One classic cycle; the request stands until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    @(posedge clock);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_sel  <= s;
    wb_wdat <= d;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (wb_ack !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus

  task rdchk(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 4'hf, 32'h0);
    check(rd, want);
  endtask : rdchk

  // Counts heartbeat level changes over a run of status reads
  task hb_count(output int t);
    logic p;
    t = 0;
    bus(1'b0, ADR_STATUS, 4'hf, 32'h0);
    p = rd[5];
    repeat (24) begin
      bus(1'b0, ADR_STATUS, 4'hf, 32'h0);
      if (rd[5] !== p) t++;
      p = rd[5];
    end
  endtask : hb_count

  initial begin
    arst_n = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 8'h00;
    wb_sel = 4'h0; wb_wdat = 32'h0; operating = 1'b0; slow = 1'b0;
    plate_stat_in = {8'h9c, 8'h9d, 8'hbe, 8'h9f}; // Second plate drives a beat bit to override
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    // Reset state
    rdchk(ADR_IRQ_STS, 32'h0);
    rdchk(ADR_ECHO, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    // Plate groups every four bytes, boundary setpoint and style values
    for (int p = 0; p < PLATES; p++) begin
      bus(1'b1, 8'(4 * p), 4'hf, {8'hf0 | 8'(p), 8'h5a, 4'hf, 12'hff0 | 12'(p)});
      check(32'(plate_cmd[p].cmd), 32'hff0 | 32'(p));
      check(32'(plate_cmd[p].ctrl), 32'h5a);
      check(32'(plate_cmd[p].style), 32'hf0 | 32'(p));
    end
    // Each control bit alone, through its own byte lane
    for (int b = 0; b < 8; b++) begin
      bus(1'b1, 8'h04, 4'b0100, 32'(8'h01 << b) << 16);
      check(32'(plate_cmd[1]), {4'h0, 8'hf1, 8'h01 << b, 12'hff1});
    end
    // Auxiliary and swirl setpoints
    bus(1'b1, 8'h10, 4'hf, 32'h0123_0456);
    bus(1'b1, 8'h14, 4'hf, 32'hffff_0001);
    check({8'h0, aux_cmd[1], aux_cmd[0]}, 32'h0012_3456);
    check({8'h0, swirl_cmd, aux_cmd[2]}, 32'h00ff_f001);
    // Spare bytes and unmapped space take no effect
    bus(1'b1, 8'h18, 4'b0011, 32'h0000_beef);
    rdchk(8'h18, 32'h0);
    check(32'(wr_cnt), 32'h0);
    bus(1'b1, 8'h40, 4'hf, 32'hffff_ffff);
    rdchk(8'h40, 32'h0);
    // Send: data first, then an odd pointer
    bus(1'b1, ADR_IRQ_EN, 4'hf, 32'h2);
    bus(1'b1, 8'h1c, 4'hf, 32'hcafe_0042);
    bus(1'b1, 8'h18, 4'b1100, 32'h0003_0000);
    repeat (4) @(posedge clock);
    check(32'(wr_cnt), 32'h1);
    check(core_req.data, 32'hcafe_0042);
    check({31'h0, irq_o}, 32'h1);
    rdchk(ADR_ECHO, 32'h0003_0000);
    rdchk(ADR_IN_DATA, 32'hcafe_0042);
    rdchk(ADR_IRQ_STS, 32'h2);
    bus(1'b1, ADR_IRQ_CLR, 4'hf, 32'h2);
    rdchk(ADR_IRQ_STS, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    // Unchanged pointer with new data is not a new request
    bus(1'b1, 8'h1c, 4'hf, 32'h1111_2222);
    bus(1'b1, 8'h18, 4'b1100, 32'h0003_0000);
    repeat (6) @(posedge clock);
    check(32'(wr_cnt), 32'h1);
    rdchk(ADR_IN_DATA, 32'hcafe_0042);
    // Fetches, slow then prompt partner; fetch-done stays masked at first
    for (int f = 0; f < 2; f++) begin
      slow <= (f == 0);
      bus(1'b1, 8'h18, 4'b1100, {16'(2 + 2 * f), 16'h0});
      n = 0;
      do begin
        bus(1'b0, ADR_IRQ_STS, 4'hf, 32'h0);
        n++;
      end while (rd[0] !== 1'b1 && n < 20);
      check(rd, 32'h1);
      if (rd[0] !== 1'b1) begin
        report_and_stop(); // A fetch that never answers ends the run here
      end
      rdchk(ADR_ECHO, {16'(2 + 2 * f), 16'h0});
      rdchk(ADR_IN_DATA, {~16'(2 + 2 * f), 16'(2 + 2 * f)});
      check({31'h0, irq_o}, 32'(f)); // Only enabled bits raise the line
      bus(1'b1, ADR_IRQ_EN, 4'hf, 32'h3);
      repeat (2) @(posedge clock);
      check({31'h0, irq_o}, 32'h1);
      bus(1'b1, ADR_IRQ_CLR, 4'hf, 32'h1);
      rdchk(ADR_IRQ_CLR, 32'h0);
      check({31'h0, irq_o}, 32'h0);
    end
    // Zero pointer and writes to read-only places do nothing
    bus(1'b1, 8'h18, 4'b1100, 32'h0);
    bus(1'b1, ADR_IRQ_STS, 4'hf, 32'h3);
    bus(1'b1, ADR_ECHO, 4'hf, 32'hffff_ffff);
    repeat (8) @(posedge clock);
    rdchk(ADR_IRQ_STS, 32'h0);
    rdchk(ADR_ECHO, 32'h0004_0000);
    // Status bytes pass through; heartbeat runs only while operating
    rdchk(ADR_STATUS, 32'h9c9d_9e9f);
    check(rd & 32'hdfdf_dfdf, 32'h9c9d_9e9f);
    check({29'h0, rd[29], rd[21], rd[13]}, {29'h0, {3{rd[5]}}});
    hb_count(ntog);
    check(32'(ntog), 32'h0);
    operating <= 1'b1;
    hb_count(ntog);
    check(32'(ntog >= 4 && ntog <= 12), 32'h1);
    report_and_stop();
  end
endmodule : dxm_top_tb_top
